//--- hdl/stc_chopper.sv
`timescale 1ns/10ps
`default_nettype none
module stc_chopper
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic sense_trip,
  input wire logic mixed,
  input wire logic [stc_pkg::CNT_W-1:0] off_cyc,
  input wire logic [stc_pkg::CNT_W-1:0] fast_cyc,
  output logic bridge_on,
  output logic fast_decay,
  output logic slow_decay,
  output logic blanking
);
  import stc_pkg::*;

  // Count parks here, so the comparator is masked for exactly BLANK_CYC cycles
  localparam logic [CNT_W-1:0] BLANK_END = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] ONE = 18'h0_0001;

  stc_chop_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic blank_done;
  logic fast_done;
  logic off_done;

  assign blank_done = (cnt_q >= BLANK_END);
  assign fast_done = (cnt_q + ONE >= fast_cyc);
  assign off_done = (cnt_q + ONE >= off_cyc);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + ONE;
    case (state_q)
      CH_IDLE: begin
        cnt_d = '0;
        if (run) begin
          state_d = CH_ON;
        end
      end
      CH_ON: begin
        if (blank_done) begin
          cnt_d = cnt_q;
        end
        // Comparator ignored until blank time expires
        if (blank_done && sense_trip) begin
          state_d = mixed ? CH_FAST : CH_SLOW;
          cnt_d = '0;
        end
      end
      CH_FAST: begin
        if (fast_done) begin
          state_d = CH_SLOW;
        end
      end
      CH_SLOW: begin
        if (off_done) begin
          state_d = CH_ON;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = CH_IDLE;
        cnt_d = '0;
      end
    endcase
    if (!run) begin
      state_d = CH_IDLE;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CH_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign bridge_on = (state_q == CH_ON);
  assign fast_decay = (state_q == CH_FAST);
  assign slow_decay = (state_q == CH_SLOW);
  assign blanking = (state_q == CH_ON) && !blank_done;

endmodule : stc_chopper
`default_nettype wire

//--- hdl/stc_pkg.sv
// Summary of operation
// - Resolution selects pick full/half/quarter/eighth step
// - Reset loads home codes, polarity, mixed decay
// - Step rising edge advances one sized increment
// - Falling code mixed decay, else slow
// - Resolution change applies at next step edge
// - Direction change applies at next step edge
// - Mixed decay: fast 31.25% then slow
// - Strap high: 30us, auto, full slow
// - Strap low: 30us, always mixed decay
// - Strap resistor: programmed off-time, auto decay
// - Reset low holds home, switches off
// - Trip clears latch, starts fixed off-time
// - Trip level is code fraction of full scale
// - Comparator masked for blank after switching
// - Thermal or overcurrent trip returns home
package stc_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int STEP_MIN_NS = 1000;
  localparam int BLANK_NS = 1000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_FIXED_US = 30;
  localparam int OFF_FIXED_CYC = OFF_FIXED_US * CYC_PER_US;
  localparam int FAST_NUM = 5;
  localparam int FAST_SHIFT = 4;
  localparam int CNT_W = 18;
  localparam int POS_W = 5;
  localparam int CODE_W = 8;
  localparam int OFFUS_W = 10;
  localparam logic [POS_W-1:0] HOME_POS = 5'h04;
  localparam logic [OFFUS_W-1:0] OFFUS_RESET = 10'h01E;

  localparam logic [3:0] REG_OFFTIME = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CODES = 4'h8;
  localparam logic [3:0] REG_STEPS = 4'hC;

  localparam int ST_POS_LSB = 0;
  localparam int ST_RES_LSB = 8;
  localparam int ST_STRAP_LSB = 12;
  localparam int ST_MIXED_LSB = 16;
  localparam int ST_HOLD_BIT = 20;
  localparam int CD_CODE2_LSB = 8;
  localparam int CD_POL_LSB = 16;

  typedef enum logic [1:0] {
    RES_FULL = 2'b00,
    RES_HALF = 2'b01,
    RES_QUARTER = 2'b10,
    RES_EIGHTH = 2'b11
  } stc_res_e;

  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_HIGH = 2'b01,
    STRAP_RES = 2'b10
  } stc_strap_e;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_ON = 2'b01,
    CH_FAST = 2'b10,
    CH_SLOW = 2'b11
  } stc_chop_e;

  // Quarter-wave cosine, k = 0..8 in 11.25 degree steps, 255 = full scale
  function automatic logic [CODE_W-1:0] stc_wave(input logic [3:0] k);
    case (k)
      4'h0: stc_wave = 8'hFF;
      4'h1: stc_wave = 8'hFA;
      4'h2: stc_wave = 8'hEC;
      4'h3: stc_wave = 8'hD4;
      4'h4: stc_wave = 8'hB4;
      4'h5: stc_wave = 8'h8E;
      4'h6: stc_wave = 8'h62;
      4'h7: stc_wave = 8'h32;
      default: stc_wave = 8'h00;
    endcase
  endfunction : stc_wave

endpackage : stc_pkg

//--- hdl/stc_top.sv
`timescale 1ns/10ps
`default_nettype none
module stc_top
  import stc_pkg::*;
#(
  parameter int OFF_FIXED_CYCLES = stc_pkg::OFF_FIXED_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host control levels
  input wire logic step,
  input wire logic direction,
  input wire logic resolution_sel_a,
  input wire logic resolution_sel_b,
  input wire logic sequencer_reset_n,
  // Off-time strap: 00 tied low, 01 tied high, 10 resistor
  input wire logic [1:0] offtime_strap,
  // Protection and sense comparators
  input wire logic thermal_trip,
  input wire logic overcurrent_trip,
  input wire logic [1:0] sense_trip,
  // Per-winding outputs
  output logic [stc_pkg::CODE_W-1:0] level_code1,
  output logic [stc_pkg::CODE_W-1:0] level_code2,
  output logic [1:0] winding_pol,
  output logic [1:0] decay_mixed,
  output logic [1:0] bridge_on,
  output logic [1:0] fast_decay,
  output logic [1:0] slow_decay,
  output logic [1:0] blanking
);
  import stc_pkg::*;

  localparam logic [CNT_W-1:0] OFF_FIX = CNT_W'(OFF_FIXED_CYCLES);
  localparam logic [CNT_W-1:0] CPU = CNT_W'(CYC_PER_US);

  // Counter width bounds the off-time; below two cycles the fast split breaks
  if (OFF_FIXED_CYCLES < 2 || OFF_FIXED_CYCLES >= (1 << CNT_W)) begin : g_bad_off
    $error("stc_top: OFF_FIXED_CYCLES out of range");
  end

  // Input synchronisers, first stage read only by second
  // Bit 0 carries the translator reset, so it starts held after reset_n
  logic [4:0] sync1_q, sync2_q;
  logic step_prev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      step_prev_q <= 1'b0;
    end else begin
      sync1_q <= {resolution_sel_b, resolution_sel_a, direction, step, sequencer_reset_n};
      sync2_q <= sync1_q;
      step_prev_q <= sync2_q[1];
    end
  end

  logic step_s;
  logic dir_s;
  logic [1:0] res_s;
  logic step_rise;
  logic hold;

  assign step_s = sync2_q[1];
  assign dir_s = sync2_q[2];
  assign res_s = sync2_q[4:3];
  assign step_rise = step_s && !step_prev_q;
  // Host keeps pulses >= 1us, so no edge is lost at this rate
  assign hold = !sync2_q[0] || thermal_trip || overcurrent_trip;

  // Strap caught once after reset release
  stc_strap_e strap_q;
  logic strap_done_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_q <= STRAP_HIGH;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q <= (offtime_strap == STRAP_LOW) ? STRAP_LOW :
                 (offtime_strap == STRAP_RES) ? STRAP_RES : STRAP_HIGH;
    end
  end

  // Translator
  stc_res_e res_q;
  logic [POS_W-1:0] pos_q;
  logic [CODE_W-1:0] code1_q, code2_q;
  logic [1:0] pol_q;
  logic [1:0] fall_q;
  logic [31:0] steps_q;
  logic home_q;

  logic [POS_W-1:0] inc;
  logic [POS_W-1:0] pos_nxt;
  logic [3:0] m_nxt;
  logic [3:0] k1;
  logic [3:0] k2;
  logic [CODE_W-1:0] code1_nxt;
  logic [CODE_W-1:0] code2_nxt;
  logic [1:0] pol_nxt;

  // Step size taken from the selects sampled at this very edge
  assign inc = (res_s == RES_FULL) ? 5'h08 :
               (res_s == RES_HALF) ? 5'h04 :
               (res_s == RES_QUARTER) ? 5'h02 : 5'h01;
  // Direction also only looked at on the edge
  assign pos_nxt = dir_s ? (pos_q + inc) : (pos_q - inc);
  assign m_nxt = pos_nxt[3:0];
  assign k1 = (m_nxt <= 4'h8) ? m_nxt : 4'(5'h10 - {1'b0, m_nxt});
  assign k2 = (m_nxt <= 4'h8) ? 4'(4'h8 - m_nxt) : 4'(m_nxt - 4'h8);
  assign code1_nxt = stc_wave(k1);
  assign code2_nxt = stc_wave(k2);
  assign pol_nxt[0] = (pos_nxt < 5'h08) || (pos_nxt > 5'h18);
  assign pol_nxt[1] = (pos_nxt < 5'h10);

  logic [3:0] k1_home;
  logic [3:0] k2_home;
  assign k1_home = {1'b0, HOME_POS[3:0]} <= 4'h8 ? HOME_POS[3:0] : 4'h8;
  assign k2_home = 4'(4'h8 - k1_home);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_q <= HOME_POS;
      res_q <= RES_FULL;
      code1_q <= stc_wave(HOME_POS[3:0]);
      code2_q <= stc_wave(4'(4'h8 - HOME_POS[3:0]));
      pol_q <= 2'b11;
      fall_q <= 2'b11;
      steps_q <= 32'h0000_0000;
      home_q <= 1'b1;
    end else if (hold) begin
      // Back to home, all step edges dropped
      pos_q <= HOME_POS;
      code1_q <= stc_wave(k1_home);
      code2_q <= stc_wave(k2_home);
      pol_q <= 2'b11;
      fall_q <= 2'b11;
      home_q <= 1'b1;
    end else if (step_rise) begin
      home_q <= 1'b0;
      pos_q <= pos_nxt;
      res_q <= stc_res_e'(res_s);
      code1_q <= code1_nxt;
      code2_q <= code2_nxt;
      pol_q <= pol_nxt;
      // Falling level picks mixed, rising or equal slow
      fall_q <= {code2_nxt < code2_q, code1_nxt < code1_q};
      steps_q <= steps_q + 32'h0000_0001;
    end
  end

  // Decay selection per strap setting
  logic [1:0] mixed_sel;
  // Home keeps both windings mixed until the first step, whatever the mode
  assign mixed_sel = (strap_q == STRAP_LOW) ? 2'b11 :
                     home_q ? 2'b11 :
                     (res_q == RES_FULL) ? 2'b00 :
                     fall_q;

  // Off-time register, in microseconds, used with the resistor strap
  logic [OFFUS_W-1:0] offus_q;
  logic [CNT_W-1:0] off_res;
  logic [CNT_W-1:0] off_cyc;
  logic [CNT_W-1:0] fast_cyc;
  logic [CNT_W+2:0] fast_prod;

  assign off_res = CNT_W'(offus_q) * CPU;
  assign off_cyc = (strap_q == STRAP_RES) ? off_res : OFF_FIX;
  assign fast_prod = (CNT_W + 3)'(off_cyc) * (CNT_W + 3)'(FAST_NUM);
  // 31.25% is exactly 5/16, so a shift replaces a divider
  assign fast_cyc = (fast_prod[CNT_W+2:FAST_SHIFT] == '0) ? 18'h0_0001 :
                    CNT_W'(fast_prod[CNT_W+2:FAST_SHIFT]);

  // Two windings share one chopper design
  logic run;
  assign run = !hold;

  for (genvar w = 0; w < 2; w++) begin : g_wind
    stc_chopper u_chop (
      .clk(clk),
      .reset_n(reset_n),
      .run(run),
      .sense_trip(sense_trip[w]),
      .mixed(mixed_sel[w]),
      .off_cyc(off_cyc),
      .fast_cyc(fast_cyc),
      .bridge_on(bridge_on[w]),
      .fast_decay(fast_decay[w]),
      .slow_decay(slow_decay[w]),
      .blanking(blanking[w])
    );
  end

  // Codes feed the trip reference as a fraction of full scale
  assign level_code1 = code1_q;
  assign level_code2 = code2_q;
  assign winding_pol = pol_q;
  assign decay_mixed = mixed_sel;

  // Wishbone slave, one wait state, unmapped reads as zero
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_off;
  logic [31:0] status_w;
  logic [31:0] codes_w;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_off = req && wb_we_i && (wb_adr_i == REG_OFFTIME);

  assign status_w = (32'(pos_q) << ST_POS_LSB) |
                    (32'(res_q) << ST_RES_LSB) |
                    (32'(strap_q) << ST_STRAP_LSB) |
                    (32'(mixed_sel) << ST_MIXED_LSB) |
                    (32'(hold) << ST_HOLD_BIT);
  assign codes_w = 32'(code1_q) |
                   (32'(code2_q) << CD_CODE2_LSB) |
                   (32'(pol_q) << CD_POL_LSB);
  assign rd_mux = (wb_adr_i == REG_OFFTIME) ? 32'(offus_q) :
                  (wb_adr_i == REG_STATUS) ? status_w :
                  (wb_adr_i == REG_CODES) ? codes_w :
                  (wb_adr_i == REG_STEPS) ? steps_q : 32'h0000_0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      offus_q <= OFFUS_RESET;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rd_mux : 32'h0000_0000;
      if (wr_off && wb_sel_i[0]) begin
        offus_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_off && wb_sel_i[1]) begin
        offus_q[OFFUS_W-1:8] <= wb_dat_i[OFFUS_W-1:8];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule : stc_top
`default_nettype wire

//--- test/stc_host.sv
`timescale 1ns/10ps
`default_nettype none
module stc_host
  import stc_pkg::*;
(
  input wire logic clk,
  output var logic step,
  output var logic direction,
  output var logic resolution_sel_a,
  output var logic resolution_sel_b,
  output var logic sequencer_reset_n
);
  initial begin
    step = 1'b0;
    direction = 1'b1;
    resolution_sel_a = 1'b0;
    resolution_sel_b = 1'b0;
    sequencer_reset_n = 1'b1;
  end
  // Levels settle 200 ns ahead of any edge
  task automatic levels(input logic dir, input logic [1:0] res);
    @(posedge clk);
    direction <= dir;
    resolution_sel_a <= res[0];
    resolution_sel_b <= res[1];
    repeat (40) @(posedge clk);
  endtask : levels
  // Mode only changes at positions shared by both modes
  task automatic pulse(input logic dir, input logic [1:0] res);
    levels(dir, res);
    step <= 1'b1;
    repeat (CYC_PER_US) @(posedge clk);
    step <= 1'b0;
    repeat (CYC_PER_US) @(posedge clk);
  endtask : pulse
  task automatic hold(input logic v);
    @(posedge clk);
    sequencer_reset_n <= v;
    repeat (4) @(posedge clk);
  endtask : hold
endmodule : stc_host
`default_nettype wire

//--- test/stc_props.sv
`timescale 1ns/10ps
`default_nettype none
module stc_props
  import stc_pkg::*;
#(
  parameter int OFF_FIXED_CYCLES = 6000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sequencer_reset_n,
  input wire logic [1:0] offtime_strap,
  input wire logic thermal_trip,
  input wire logic overcurrent_trip,
  input wire logic [1:0] sense_trip,
  input wire logic [stc_pkg::CODE_W-1:0] level_code1,
  input wire logic [stc_pkg::CODE_W-1:0] level_code2,
  input wire logic [1:0] decay_mixed,
  input wire logic [1:0] bridge_on,
  input wire logic [1:0] fast_decay,
  input wire logic [1:0] slow_decay,
  input wire logic [1:0] blanking
);
  localparam logic [17:0] FAST_EXP = 18'((OFF_FIXED_CYCLES * FAST_NUM) >> FAST_SHIFT);
  logic [17:0] blank_q, off_q, fast_q;
  // Hold may act without a flop, so it excuses the consequent of the trip and blank-mask checks
  wire logic quiet = !thermal_trip && !overcurrent_trip && sequencer_reset_n;
  wire logic off0 = fast_decay[0] | slow_decay[0];
  wire logic fixed = offtime_strap != 2'b10;
  wire logic home = level_code1 == 8'hB4 && level_code2 == 8'hB4;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_q <= '0;
      off_q <= '0;
      fast_q <= '0;
    end else begin
      blank_q <= blanking[0] ? blank_q + 18'h1 : '0;
      off_q <= off0 ? off_q + 18'h1 : '0;
      fast_q <= fast_decay[0] ? fast_q + 18'h1 : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_hold;
    thermal_trip || overcurrent_trip;
  endsequence
  sequence s_trip;
    bridge_on[0] && !blanking[0] && sense_trip[0] && quiet;
  endsequence
  chk_trip_mixed: assert property (s_trip ##0 decay_mixed[0] |=> fast_decay[0] || !quiet)
    else $error("mixed trip did not start fast decay");
  chk_trip_slow: assert property (s_trip ##0 !decay_mixed[0] |=> slow_decay[0] || !quiet)
    else $error("slow trip did not start slow decay");
  chk_blank_mask: assert property (blanking[0] && sense_trip[0] && quiet |=> bridge_on[0] || !quiet)
    else $error("trip seen while blanked");
  chk_blank_len: assert property ($fell(blanking[0]) && bridge_on[0] |-> blank_q == 18'(BLANK_CYC))
    else $error("blanking length wrong");
  chk_fast_len: assert property ($fell(fast_decay[0]) && slow_decay[0] && fixed |-> fast_q == FAST_EXP)
    else $error("fast decay length wrong");
  chk_off_len: assert property ($fell(off0) && bridge_on[0] && fixed |-> off_q == 18'(OFF_FIXED_CYCLES))
    else $error("off time length wrong");
  chk_hold_home: assert property (s_hold [*3] |-> home && bridge_on == 2'b00 && !off0)
    else $error("trip did not hold home with outputs off");
  chk_seq_home: assert property (!sequencer_reset_n [*4] |-> home && bridge_on == 2'b00)
    else $error("translator reset did not hold home");
  chk_strap_low: assert property (offtime_strap == 2'b00 |-> decay_mixed == 2'b11)
    else $error("grounded strap not mixed");
endmodule : stc_props
`default_nettype wire

//--- test/stepper_translator_chopper_tb.sv
`timescale 1ns/10ps
`default_nettype none
module stepper_translator_chopper_tb;
  import stc_pkg::*;
  localparam int OFFC = 64;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [1:0] offtime_strap = 2'b01;
  logic thermal_trip = 1'b0;
  logic overcurrent_trip = 1'b0;
  logic [1:0] sense_trip = 2'b00;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, step, direction, resolution_sel_a, resolution_sel_b, sequencer_reset_n;
  logic [7:0] level_code1, level_code2;
  logic [1:0] winding_pol, decay_mixed, bridge_on, fast_decay, slow_decay, blanking;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  stc_top #(.OFF_FIXED_CYCLES(OFFC)) i_dut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .step, .direction,
    .resolution_sel_a, .resolution_sel_b, .sequencer_reset_n, .offtime_strap, .thermal_trip,
    .overcurrent_trip, .sense_trip, .level_code1, .level_code2, .winding_pol, .decay_mixed,
    .bridge_on, .fast_decay, .slow_decay, .blanking);
  stc_host i_host (.clk, .step, .direction, .resolution_sel_a, .resolution_sel_b,
    .sequencer_reset_n);
  always #2.5 clk = ~clk;
  // Current always overshoots, so only blanking delays each trip
  always @(posedge clk) sense_trip <= bridge_on;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    reset_n <= 1'b0;
    offtime_strap <= s;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset
  // Skips the off phase in progress so a new off-time is seen whole
  task automatic measure(input int ef, input int et);
    int fc;
    int tc;
    fc = 0;
    tc = 0;
    #1;
    // Phases: wait for on, wait for off, then count the off phase
    for (int ph = 0; ph < 3; ph++) begin
      while (bridge_on[0] !== (ph != 1)) begin
        fc += int'(ph == 2 && fast_decay[0] === 1'b1);
        tc += int'(ph == 2);
        @(posedge clk);
        #1;
      end
    end
    cmp("fast cycles", 32'(ef), 32'(fc));
    cmp("off cycles", 32'(et), 32'(tc));
  endtask : measure
  task automatic step_chk(input logic dir, input logic [1:0] res, input logic [7:0] c1,
                          input logic [7:0] c2, input logic [1:0] dm);
    i_host.pulse(dir, res);
    cmp("level_code1", 32'(c1), 32'(level_code1));
    cmp("level_code2", 32'(c2), 32'(level_code2));
    cmp("decay_mixed", 32'(dm), 32'(decay_mixed));
  endtask : step_chk
  task automatic t_home;
    repeat (3) @(posedge clk);
    #1;
    cmp("winding_pol", 32'h0000_0003, 32'(winding_pol));
    cmp("decay_mixed", 32'h0000_0003, 32'(decay_mixed));
    measure((OFFC * FAST_NUM) >> FAST_SHIFT, OFFC);
  endtask : t_home
  task automatic t_regs;
    wb(1'b0, REG_OFFTIME, '0);
    cmp("offtime", 32'h0000_001E, rd);
    wb(1'b1, REG_OFFTIME, 32'h0000_0001);
    wb(1'b0, REG_OFFTIME, '0);
    cmp("offtime", 32'h0000_0001, rd);
    wb(1'b0, 4'h2, '0);
    cmp("unmapped", 32'h0000_0000, rd);
    wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    wb(1'b0, REG_STATUS, '0);
    cmp("position", 32'h0000_0004, rd & 32'h0000_001F);
  endtask : t_regs
  task automatic t_steps;
    step_chk(1'b1, RES_EIGHTH, 8'h8E, 8'hD4, 2'b01);
    step_chk(1'b0, RES_EIGHTH, 8'hB4, 8'hB4, 2'b10);
    i_host.levels(1'b1, RES_FULL);
    wb(1'b0, REG_STATUS, '0);
    cmp("resolution", 32'h0000_0003, (rd >> 8) & 32'h0000_0003);
    step_chk(1'b1, RES_FULL, 8'hB4, 8'hB4, 2'b00);
    cmp("winding_pol", 32'h0000_0002, 32'(winding_pol));
    measure(0, OFFC);
    step_chk(1'b1, RES_HALF, 8'hFF, 8'h00, 2'b10);
    step_chk(1'b1, RES_QUARTER, 8'hEC, 8'h62, 2'b01);
    wb(1'b0, REG_STATUS, '0);
    cmp("position", 32'h0000_0012, rd & 32'h0000_001F);
    wb(1'b0, REG_CODES, '0);
    cmp("codes", 32'h0000_62EC, rd);
    wb(1'b0, REG_STEPS, '0);
    cmp("steps", 32'h0000_0005, rd);
  endtask : t_steps
  task automatic t_hold;
    for (int i = 0; i < 2; i++) begin
      i_host.pulse(1'b1, RES_EIGHTH);
      {overcurrent_trip, thermal_trip} <= (i == 1) ? 2'b10 : 2'b01;
      repeat (5) @(posedge clk);
      {overcurrent_trip, thermal_trip} <= 2'b00;
      cmp("level_code1", 32'h0000_00B4, 32'(level_code1));
      cmp("bridge_on", 32'h0000_0000, 32'(bridge_on));
    end
    // Leave home first, so the translator reset has something to undo
    i_host.pulse(1'b1, RES_EIGHTH);
    i_host.hold(1'b0);
    i_host.pulse(1'b1, RES_EIGHTH);
    cmp("level_code1", 32'h0000_00B4, 32'(level_code1));
    cmp("bridge_on", 32'h0000_0000, 32'(bridge_on));
    i_host.hold(1'b1);
  endtask : t_hold
  task automatic t_straps;
    do_reset(2'b00);
    step_chk(1'b1, RES_FULL, 8'hB4, 8'hB4, 2'b11);
    measure((OFFC * FAST_NUM) >> FAST_SHIFT, OFFC);
    do_reset(2'b10);
    wb(1'b1, REG_OFFTIME, 32'h0000_0001);
    measure((CYC_PER_US * FAST_NUM) >> FAST_SHIFT, CYC_PER_US);
    step_chk(1'b1, RES_FULL, 8'hB4, 8'hB4, 2'b00);
  endtask : t_straps
  initial begin
    do_reset(2'b01);
    t_home();
    t_regs();
    t_steps();
    t_hold();
    t_straps();
    results();
  end
endmodule : stepper_translator_chopper_tb
bind stc_top stc_props #(.OFF_FIXED_CYCLES(OFF_FIXED_CYCLES)) i_props (.clk, .reset_n,
  .sequencer_reset_n, .offtime_strap, .thermal_trip, .overcurrent_trip, .sense_trip,
  .level_code1, .level_code2, .decay_mixed, .bridge_on, .fast_decay, .slow_decay, .blanking);
`default_nettype wire
